// file: rtl/sleep_wake_seq.sv
// Sleep/wake sequencer and processor reset release
//Behaviour
//RQ1: Sleep request starts sequence unless irq pending (code also needs sleep_mask clear; reset sets it)
//RQ2: Only irq or sleep release wakes
//RQ3: Unassigned resource always stays active
//RQ4: Sleep-pin resources switch in sequence order
//RQ5: Direct-pin resources switch together, immediately
//RQ6: Both-pin resource active if either pin active
//RQ7: Pin polarity selectable, direct pin high default
//RQ8: Sleep pin active low by default
//RQ9: Assignment registers per resource class, writable
//RQ10: Mode in each state from regulator register (code: register sets sleep mode only; active is always MODE_ON)
//RQ11: Sequence steps resources with stored delays
//RQ12: Unsequenced resource stays off until software
//RQ13: Reset release waits sequence and crystal clock
//RQ14: Bypassed oscillator waits external clock stable
//RQ15: Gating bit releases reset without clock wait
//RQ16: First rail waits six ms after POR
//RQ17: Host toggles sleep after off-to-active restart
//RQ18: Off request overrides sleep and wake
//RQ19: Sleep only in idle active; wake deferred
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "pwr_seq_cfg.svh"
module sleep_wake_seq
	import pwr_seq_pkg::*;
#(
	parameter int POR_WAIT = `POR_WAIT_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire pwr_seq_pkg::reg_req_t req,
	output logic [7:0] rdata,
	// Control pins and status inputs
	input wire pwr_seq_pkg::ctl_in_t ctl,
	// Resource modes and processor reset
	output pwr_seq_pkg::ctl_out_t outs
);
	import pwr_seq_pkg::*;

	localparam int N = NUM_RES;

	typedef struct packed {
		pwr_state_t st;
		logic [22:0] wait_cnt;
		logic [7:0] step_cnt;
		logic [2:0] idx;
		logic [N-1:0] seq_assign;
		logic [N-1:0] dir_assign;
		logic [7:0] polarity;
		logic sleep_mask;
		logic [7:0] seq_delay;
		logic [N-1:0] res_on;
		logic [N-1:0] res_sleep_seq;
		logic [N-1:0] in_seq;
		logic [N-1:0] sw_on;
		logic [N*2-1:0] mode_ctrl;
		logic up_done;
		logic wake_pend;
		logic wake_to_off;
		logic [7:0] rdata;
	} core_state_t;

	core_state_t cur;
	core_state_t next_cur;

	logic sleep_sync;
	logic direct_sync;
	logic sleep_act;
	logic direct_act;
	logic clk_ok;
	logic [N*2-1:0] mode_vec;

	pin_sync u_sleep_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pin(ctl.sleep_request_pin),
		.init(1'b1),
		.level(sleep_sync)
	);

	pin_sync u_direct_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.pin(ctl.direct_mode_pin),
		.init(1'b0),
		.level(direct_sync)
	);

	// Polarity bit set means the pin is active high
	assign sleep_act = sleep_sync ~^ cur.polarity[`POL_SLEEP_BIT]; // [RQ7] [RQ8]
	assign direct_act = direct_sync ~^ cur.polarity[`POL_DIRECT_BIT]; // [RQ7]

	// Clock gate for reset release
	always_comb begin
		if (ctl.gate_reset_otp)
			clk_ok = 1'b1; // [RQ15]
		else if (ctl.osc_bypassed)
			clk_ok = ctl.ext_clk_stable; // [RQ14]
		else if (ctl.xtal_present && ctl.osc_enabled)
			clk_ok = ctl.xtal_stable; // [RQ13]
		else
			// No usable clock source: keep the processor in reset
			clk_ok = 1'b0; // [RQ13] [RQ14]
	end

	// Per-resource mode resolution
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_res
			logic asleep;
			logic [1:0] slp_mode;
			always_comb begin
				slp_mode = cur.mode_ctrl[g*2 +: 2]; // [RQ10]
				if (!cur.seq_assign[g] && !cur.dir_assign[g])
					asleep = 1'b0; // [RQ3]
				else if (cur.seq_assign[g] && cur.dir_assign[g])
					// Either active pin holds it active
					asleep = !sleep_act ? 1'b0 : // [RQ6]
						(direct_act ? 1'b0 :
						cur.res_sleep_seq[g]);
				else if (cur.dir_assign[g])
					asleep = !direct_act; // [RQ5]
				else
					asleep = cur.res_sleep_seq[g]; // [RQ4]
				if (!cur.res_on[g] && !cur.sw_on[g])
					mode_vec[g*2 +: 2] = MODE_OFF; // [RQ12]
				else if (asleep && cur.up_done)
					mode_vec[g*2 +: 2] = slp_mode; // [RQ10]
				else
					mode_vec[g*2 +: 2] = MODE_ON;
			end
		end
	endgenerate

	always_comb begin
		next_cur = cur;
		next_cur.rdata = 8'h00;
		if (cur.step_cnt != 8'h00)
			next_cur.step_cnt = cur.step_cnt - 8'h01;

		// Register writes
		if (req.wr) begin
			case (req.addr)
			`REG_SEQ_ASSIGN_GEN: next_cur.seq_assign[1:0] = req.wdata[1:0]; // [RQ9]
			`REG_SEQ_ASSIGN_SMPS: next_cur.seq_assign[4:2] = req.wdata[2:0]; // [RQ9]
			`REG_SEQ_ASSIGN_LDO: next_cur.seq_assign[7:5] = req.wdata[2:0]; // [RQ9]
			`REG_DIR_ASSIGN_GEN: next_cur.dir_assign[1:0] = req.wdata[1:0]; // [RQ9]
			`REG_DIR_ASSIGN_SMPS: next_cur.dir_assign[4:2] = req.wdata[2:0]; // [RQ9]
			`REG_DIR_ASSIGN_LDO: next_cur.dir_assign[7:5] = req.wdata[2:0]; // [RQ9]
			`REG_POLARITY: next_cur.polarity = req.wdata;
			`REG_SLEEP_MASK: next_cur.sleep_mask = req.wdata[0];
			`REG_SEQ_DELAY: next_cur.seq_delay = req.wdata;
			`REG_RES_ON: begin
				// Software may only take over after the power-up sequence
				if (cur.up_done)
					next_cur.sw_on = req.wdata; // [RQ12]
			end
			default: begin
				if (req.addr[7:3] == 5'h02)
					next_cur.mode_ctrl[req.addr[2:0]*2 +: 2] =
						req.wdata[1:0]; // [RQ10]
			end
			endcase
		end

		// Register reads
		if (req.rd) begin
			case (req.addr)
			`REG_SEQ_ASSIGN_GEN: next_cur.rdata = {6'h00, cur.seq_assign[1:0]};
			`REG_SEQ_ASSIGN_SMPS: next_cur.rdata = {5'h00, cur.seq_assign[4:2]};
			`REG_SEQ_ASSIGN_LDO: next_cur.rdata = {5'h00, cur.seq_assign[7:5]};
			`REG_DIR_ASSIGN_GEN: next_cur.rdata = {6'h00, cur.dir_assign[1:0]};
			`REG_DIR_ASSIGN_SMPS: next_cur.rdata = {5'h00, cur.dir_assign[4:2]};
			`REG_DIR_ASSIGN_LDO: next_cur.rdata = {5'h00, cur.dir_assign[7:5]};
			`REG_POLARITY: next_cur.rdata = cur.polarity;
			`REG_SLEEP_MASK: next_cur.rdata = {7'h00, cur.sleep_mask};
			`REG_SEQ_DELAY: next_cur.rdata = cur.seq_delay;
			`REG_STATUS: next_cur.rdata = {2'h0, cur.st};
			`REG_RES_ON: next_cur.rdata = cur.res_on | cur.sw_on;
			`REG_RES_SLEEP: next_cur.rdata = cur.res_sleep_seq;
			default: begin
				if (req.addr[7:3] == 5'h02)
					next_cur.rdata = {6'h00,
						cur.mode_ctrl[req.addr[2:0]*2 +: 2]};
			end
			endcase
		end

		case (cur.st)
		ST_POR_WAIT: begin
			// First rail held off until the memory has settled
			if (cur.wait_cnt == 23'(POR_WAIT - 1)) begin // [RQ16]
				next_cur.st = ST_OFF_TO_ACTIVE_SEQ;
				next_cur.idx = 3'h0;
				next_cur.step_cnt = 8'h00;
			end else
				next_cur.wait_cnt = cur.wait_cnt + 23'h1;
		end
		ST_OFF_TO_ACTIVE_SEQ: begin
			// One resource per step, stored delay between steps
			if (cur.step_cnt == 8'h00) begin // [RQ11]
				if (cur.in_seq[cur.idx])
					next_cur.res_on[cur.idx] = 1'b1;
				next_cur.step_cnt = cur.seq_delay;
				next_cur.idx = cur.idx + 3'h1;
				if (cur.idx == 3'(N - 1)) begin
					next_cur.up_done = 1'b1;
					next_cur.st = ST_ACTIVE;
				end
			end
		end
		ST_ACTIVE: begin
			if (sleep_act && !cur.sleep_mask && !ctl.irq_pending) begin // [RQ1] [RQ19]
				next_cur.st = ST_ACTIVE_TO_SLEEP_SEQ;
				next_cur.idx = 3'h0;
				next_cur.step_cnt = 8'h00;
			end
		end
		ST_ACTIVE_TO_SLEEP_SEQ: begin
			if (!sleep_act || ctl.irq_pending)
				next_cur.wake_pend = 1'b1; // [RQ19]
			if (cur.step_cnt == 8'h00) begin // [RQ4] [RQ11]
				next_cur.res_sleep_seq[cur.idx] = cur.seq_assign[cur.idx];
				next_cur.step_cnt = cur.seq_delay;
				next_cur.idx = cur.idx + 3'h1;
				if (cur.idx == 3'(N - 1))
					next_cur.st = ST_SLEEP;
			end
		end
		ST_SLEEP: begin
			if (cur.wake_pend || !sleep_act || ctl.irq_pending) begin // [RQ2]
				next_cur.wake_pend = 1'b0;
				next_cur.st = ST_SLP_EXIT;
				next_cur.idx = 3'(N - 1);
				next_cur.step_cnt = 8'h00;
			end
		end
		ST_SLP_EXIT: begin
			// Wake undoes the sleep order in reverse
			if (cur.step_cnt == 8'h00) begin // [RQ4] [RQ11]
				next_cur.res_sleep_seq[cur.idx] = 1'b0;
				next_cur.step_cnt = cur.seq_delay;
				next_cur.idx = cur.idx - 3'h1;
				if (cur.idx == 3'h0)
					next_cur.st = ST_ACTIVE;
			end
		end
		default: next_cur.st = ST_POR_WAIT;
		endcase

		// Off request beats everything except the POR wait, where it is ignored; restart through power-up
		if (ctl.off_request && cur.st != ST_POR_WAIT) begin // [RQ18]
			next_cur.st = ST_OFF_TO_ACTIVE_SEQ;
			next_cur.res_on = '0;
			next_cur.sw_on = '0;
			next_cur.res_sleep_seq = '0;
			next_cur.up_done = 1'b0;
			next_cur.wake_pend = 1'b0;
			next_cur.idx = 3'h0;
			next_cur.step_cnt = cur.seq_delay;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.st <= ST_POR_WAIT;
			cur.polarity <= `POLARITY_RST;
			cur.sleep_mask <= `SLEEP_MASK_RST; // [RQ1]
			cur.seq_delay <= `SEQ_DELAY_RST;
			cur.in_seq <= 8'h3f;
			cur.mode_ctrl <= {N{2'h2}};
		end else if (clk_en) begin
			cur <= next_cur;
		end
	end

	assign rdata = cur.rdata;
	assign outs.res_mode = mode_vec;
	assign outs.proc_reset_n = cur.up_done && clk_ok; // [RQ13] [RQ14] [RQ15]
	assign outs.state = cur.st;
endmodule // sleep_wake_seq

// file: rtl/pwr_seq_cfg.svh
// Offsets, reset values and timing counts of the sleep/wake sequencer
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH

// Register offsets
`define REG_SEQ_ASSIGN_GEN 8'h00
`define REG_SEQ_ASSIGN_SMPS 8'h01
`define REG_SEQ_ASSIGN_LDO 8'h02
`define REG_DIR_ASSIGN_GEN 8'h03
`define REG_DIR_ASSIGN_SMPS 8'h04
`define REG_DIR_ASSIGN_LDO 8'h05
`define REG_POLARITY 8'h06
`define REG_SLEEP_MASK 8'h07
`define REG_MODE_CTRL_BASE 8'h10
`define REG_SEQ_DELAY 8'h08
`define REG_STATUS 8'h09
`define REG_RES_ON 8'h0a
`define REG_RES_SLEEP 8'h0b
`define REG_WAKE_TARGET 8'h0c

// Field positions
`define POL_SLEEP_BIT 0
`define POL_DIRECT_BIT 1

// Reset values
`define POLARITY_RST 8'h02
`define SLEEP_MASK_RST 1'b1
`define SEQ_DELAY_RST 8'h04
`define MODE_CTRL_RST 8'h01

// Timing
`define CLOCK_HZ 25000000
`define POR_WAIT_MS 6
`define POR_WAIT_CYCLES ((`POR_WAIT_MS * `CLOCK_HZ + 999) / 1000)

`endif

// file: rtl/pwr_seq_pkg.sv
// Types shared by the sleep/wake sequencer
package pwr_seq_pkg;
	localparam int NUM_RES = 8;

	typedef enum logic [5:0] {
		ST_POR_WAIT = 6'b000001,
		ST_OFF_TO_ACTIVE_SEQ = 6'b000010,
		ST_ACTIVE = 6'b000100,
		ST_ACTIVE_TO_SLEEP_SEQ = 6'b001000,
		ST_SLEEP = 6'b010000,
		ST_SLP_EXIT = 6'b100000
	} pwr_state_t;

	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_ON = 2'h1,
		MODE_SLEEP = 2'h2
	} res_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic sleep_request_pin;
		logic direct_mode_pin;
		logic xtal_present;
		logic osc_enabled;
		logic xtal_stable;
		logic osc_bypassed;
		logic ext_clk_stable;
		logic gate_reset_otp;
		logic irq_pending;
		logic off_request;
	} ctl_in_t;

	typedef struct packed {
		logic [NUM_RES*2-1:0] res_mode;
		logic proc_reset_n;
		logic [5:0] state;
	} ctl_out_t;
endpackage

// file: rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Pin
	input wire logic pin,
	input wire logic init,
	output logic level
);
	typedef struct packed {
		logic [2:0] sh;
		logic lvl;
	} sync_state_t;
	sync_state_t cur;
	sync_state_t next_cur;

	always_comb begin
		next_cur = cur;
		// Stored relative to the idle level, so reset stays constant
		next_cur.sh = {cur.sh[1:0], pin ^ init};
		// Stage 0 is only read by stage 1
		if (cur.sh[1] == cur.sh[2])
			next_cur.lvl = cur.sh[2];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			cur <= '0;
		else if (clk_en)
			cur <= next_cur;
	end

	// Idle level after reset, so no false edge follows reset
	assign level = cur.lvl ^ init;
endmodule // pin_sync

// file: tb/host_pins.sv
// Host model driving the sleep and direct control pins
`timescale 1ns/1ps
module host_pins (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Commands from the bench
	input wire logic sleep_cmd,
	input wire logic direct_cmd,
	input wire logic [3:0] lag,
	// Pins
	output logic sleep_request_pin,
	output logic direct_mode_pin
);
	logic [3:0] cnt;
	// A slow host only updates its pins every lag+1 cycles
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sleep_request_pin <= 1'b1;
			direct_mode_pin <= 1'b1;
			cnt <= 4'h0;
		end else if (cnt < lag) begin
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
			sleep_request_pin <= sleep_cmd;
			direct_mode_pin <= direct_cmd;
		end
	end
endmodule // host_pins

// file: tb/sleep_wake_seq_properties.sv
// Port checker of the sleep/wake sequencer
`timescale 1ns/1ps
module sleep_wake_seq_chk
	import pwr_seq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire pwr_seq_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	// Pins and outputs
	input wire pwr_seq_pkg::ctl_in_t ctl,
	input wire pwr_seq_pkg::ctl_out_t outs
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire [5:0] s = outs.state;
	property p_hold;
		s inside {6'h01, 6'h02} |-> !outs.proc_reset_n;
	endproperty
	a_hold: assert property (p_hold) else $error("early release");
	property p_src;
		outs.proc_reset_n |-> ctl.gate_reset_otp
			|| ctl.osc_bypassed && ctl.ext_clk_stable
			|| ctl.xtal_present && ctl.osc_enabled && ctl.xtal_stable;
	endproperty
	a_src: assert property (p_src) else $error("no clock");
	property p_por;
		s == 6'h01 |-> outs.res_mode == 16'h0;
	endproperty
	a_por: assert property (p_por) else $error("rail early");
	property p_off;
		ctl.off_request && clk_en |=> s inside {6'h01, 6'h02};
	endproperty
	a_off: assert property (p_off) else $error("off lost");
	property p_irq;
		s == 6'h04 && ctl.irq_pending && clk_en |=> s != 6'h08;
	endproperty
	a_irq: assert property (p_irq) else $error("slept on irq");
	property p_end;
		s == 6'h08 |=> s inside {6'h08, 6'h10, 6'h01, 6'h02};
	endproperty
	a_end: assert property (p_end) else $error("bad exit");
	property p_wake;
		s == 6'h10 && ctl.irq_pending && clk_en |=> s != 6'h10;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_new;
		s == 6'h02 |-> outs.res_mode[15:12] == 4'h0;
	endproperty
	a_new: assert property (p_new) else $error("extra on");
endmodule // sleep_wake_seq_chk

bind sleep_wake_seq sleep_wake_seq_chk i_chk (.clock(clock), .rst_n(rst_n),
	.clk_en(clk_en), .req(req), .rdata(rdata), .ctl(ctl), .outs(outs));

// file: tb/sleep_wake_seq_tb.sv
// Self-checking bench of the sleep/wake sequencer
`timescale 1ns/1ps
module sleep_wake_seq_tb;
	import pwr_seq_pkg::*;
	logic clock, rst_n, clk_en, sleep_cmd, direct_cmd, sp, dp;
	logic [3:0] lag;
	logic [7:0] cin, rdata;
	reg_req_t req;
	ctl_in_t ctl;
	ctl_out_t outs;
	wire [15:0] m = outs.res_mode;
	int bad_count, n_checks, n, j, bad_ord;
	// Clock status bits, then expected reset release
	logic [6:0] rows [8] = '{7'h60, 7'h71, 7'h30, 7'h50, 7'h08, 7'h0d,
		7'h04, 7'h03};
	assign ctl = {sp, dp, cin};
	host_pins i_host (.clock(clock), .rst_n(rst_n), .sleep_cmd(sleep_cmd),
		.direct_cmd(direct_cmd), .lag(lag), .sleep_request_pin(sp),
		.direct_mode_pin(dp));
	sleep_wake_seq #(.POR_WAIT(20)) i_dut (.clock(clock), .rst_n(rst_n),
		.clk_en(clk_en), .req(req), .rdata(rdata), .ctl(ctl), .outs(outs));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [23:0] g, e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		req <= {a, d, 2'b10};
		@(posedge clock);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clock);
		req <= {a, 8'h00, 2'b01};
		@(posedge clock);
		req <= '0;
		@(negedge clock);
		check(24'(rdata), 24'(e));
	endtask
	task automatic wait_st(input logic [5:0] s);
		for (int k = 0; k < 400 && outs.state !== s; k++) @(negedge clock);
		check(24'(outs.state), 24'(s));
		if (outs.state !== s) end_of_test();
	endtask
	// Ends on a rising edge so the caller may drive at once
	task automatic wait_chg(input logic [5:0] v, e);
		for (int k = 0; k < 60 && m[9:4] === v; k++) @(negedge clock);
		check(24'(m[9:4]), 24'(e));
		if (m[9:4] !== e) end_of_test();
		@(posedge clock);
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		req = '0;
		cin = 8'he0;
		sleep_cmd = 1'b1;
		direct_cmd = 1'b1;
		lag = 4'h0;
		bad_count = 0;
		n_checks = 0;
		bad_ord = 0;
		repeat (12) @(posedge clock);
		check(24'(outs), 24'h1);
		rst_n <= 1'b1;
		for (n = 0; n < 99 && outs.state === 6'h01; n++) @(negedge clock);
		check(24'(n > 18), 24'h1);
		wait_st(6'h04);
		check(24'(m[15:12]), 24'h0);
		rd(8'h06, 8'h02);
		rd(8'h07, 8'h01);
		rd(8'h08, 8'h04);
		rd(8'h40, 8'h00);
		wr(8'h00, 8'h5a);
		rd(8'h00, 8'h02);
		foreach (rows[i]) begin
			@(posedge clock);
			cin[7:2] <= rows[i][6:1];
			@(negedge clock);
			check(24'(outs.proc_reset_n), 24'(rows[i][0]));
		end
		$display("end power-up");
		@(posedge clock);
		cin <= 8'he0;
		wr(8'h00, 8'h03);
		wr(8'h01, 8'h07);
		wr(8'h02, 8'h07);
		for (j = 3; j < 6; j++) wr(8'(j), 8'h00);
		for (j = 0; j < 6; j++) wr(8'h10 + 8'(j), j ? 8'h02 : 8'h00);
		wr(8'h07, 8'h00);
		cin[1] <= 1'b1;
		sleep_cmd <= 1'b0;
		repeat (12) @(negedge clock);
		check(24'(outs.state), 24'h04);
		@(posedge clock);
		cin[1] <= 1'b0;
		for (n = 0; n < 400 && outs.state !== 6'h10; n++) begin
			@(negedge clock);
			for (j = 1; j < 6; j++)
				if (m[2*j+:2] != 2'h1 && m[2*j-2+:2] == 2'h1) bad_ord++;
		end
		check(24'(bad_ord), 24'h0);
		check(24'(m[11:0]), 24'haa8);
		@(posedge clock);
		cin[1] <= 1'b1;
		clk_en <= 1'b0;
		repeat (4) @(negedge clock);
		check(24'(outs.state), 24'h10);
		@(posedge clock);
		clk_en <= 1'b1;
		sleep_cmd <= 1'b1;
		wait_st(6'h04);
		check(24'(m[11:0]), 24'h555);
		$display("end sleep");
		@(posedge clock);
		cin[1] <= 1'b0;
		wr(8'h01, 8'h00);
		wr(8'h02, 8'h00);
		wr(8'h04, 8'h07);
		direct_cmd <= 1'b0;
		wait_chg(6'h15, 6'h2a);
		direct_cmd <= 1'b1;
		wait_chg(6'h2a, 6'h15);
		wr(8'h01, 8'h07);
		sleep_cmd <= 1'b0;
		wait_st(6'h10);
		check(24'(m[11:4]), 24'h55);
		@(posedge clock);
		direct_cmd <= 1'b0;
		wait_chg(6'h15, 6'h2a);
		direct_cmd <= 1'b1;
		sleep_cmd <= 1'b1;
		lag <= 4'h3;
		wait_st(6'h04);
		wr(8'h06, 8'h03);
		wait_st(6'h10);
		wr(8'h06, 8'h02);
		wait_st(6'h04);
		$display("end pins");
		@(posedge clock);
		sleep_cmd <= 1'b0;
		wait_st(6'h08);
		@(posedge clock);
		cin[0] <= 1'b1;
		repeat (2) @(negedge clock);
		check(24'(outs.state & 6'h3c), 24'h0);
		@(posedge clock);
		cin[0] <= 1'b0;
		sleep_cmd <= 1'b1;
		wait_st(6'h04);
		check(24'(m[15:12]), 24'h0);
		wr(8'h0a, 8'hc0);
		@(negedge clock);
		check(24'(m[15:12]), 24'h5);
		$display("end off");
		end_of_test();
	end
endmodule // sleep_wake_seq_tb
